// File: sac_pkg.sv
package sac_pkg;
   // ********************************************************************
   // command opcodes
   // ********************************************************************
   localparam logic [7:0] OP_STATUS_RD  = 8'h05;
   localparam logic [7:0] OP_WAKE       = 8'hAB;
   localparam logic [7:0] OP_SLEEP      = 8'h79;
   localparam logic [7:0] OP_ABORT      = 8'hF0;
   localparam logic [7:0] OP_ABORT_CONF = 8'hD0;
   localparam logic [7:0] OP_STAT2_WR   = 8'h31;
   localparam logic [7:0] OP_WR_EN      = 8'h06;

   // ********************************************************************
   // status field positions and values
   // ********************************************************************
   localparam int         ST1_BUSY      = 0;
   localparam int         ST1_WEL       = 1;
   localparam int         ST1_ERR       = 5;
   localparam int         ST2_AUTOSLP   = 3;
   localparam int         ST2_ABORTEN   = 6;
   localparam logic [7:0] STATUS_ASLEEP = 8'hFF;
   localparam logic       RST_WEL       = 1'b0;
   localparam logic       RST_ABORTEN   = 1'b0;
   localparam logic       RST_AUTOSLP   = 1'b0;
   localparam logic       RST_ERR       = 1'b0;
   localparam logic       RST_OCTAL     = 1'b0;

   // ********************************************************************
   // link bit counting and in-band reset
   // ********************************************************************
   localparam int         BITS_W      = 5;
   localparam logic [4:0] BITS_MAX    = 5'h1F;
   localparam logic [4:0] BYTE0_BITS  = 5'h08;
   localparam logic [4:0] BYTE1_BITS  = 5'h10;
   localparam logic [3:0] INBAND_PAT  = 4'h5;
   localparam logic [2:0] INBAND_LEN  = 3'h4;

   // operation kinds reported by the array engine
   localparam logic [1:0] KIND_ERASE  = 2'h0;
   localparam logic [1:0] KIND_PROG   = 2'h1;
   localparam logic [1:0] KIND_BUF2AR = 2'h2;
   localparam logic [1:0] KIND_OTHER  = 2'h3;

   // ********************************************************************
   // timing
   // ********************************************************************
   localparam int CLK_PERIOD_NS  = 10;
   localparam int CNT_W          = 16;
   localparam int SLEEP_ENTRY_NS = 3000;
   localparam int SLEEP_EXIT_NS  = 100000;
   // longest times round down
   localparam int SLEEP_ENTRY_CYC = SLEEP_ENTRY_NS / CLK_PERIOD_NS;
   localparam int SLEEP_EXIT_CYC  = SLEEP_EXIT_NS / CLK_PERIOD_NS;

   typedef enum logic [2:0] {
      SAC_STANDBY,
      SAC_ENTERING,
      SAC_SLEEP,
      SAC_WAKING,
      SAC_PINHOLD
   } sac_state_t;
endpackage : sac_pkg

// File: sac_ctrl.sv
// Behaviour
// - asleep, only status byte 1 read and wake are recognised; all else ignored.
// - status reads while asleep return all ones.
// - sleep opcode then chip select rise enters sleep within entry time.
// - bytes after the sleep opcode do not change the outcome.
// - chip select rising before full sleep opcode abandons the command.
// - after power cycle the device starts in standby.
// - sleep opcode ignored while program or erase runs.
// - waking restores defaults except the program/erase error flag.
// - wake-up always in single-line serial mode.
// - auto-sleep after erase, program, buffer-to-array; not buffer/register writes.
// - entering sleep clears the auto-sleep enable bit.
// - auto-sleep forces single-line mode soon after the operation starts.
// - only wake command, in-band reset, reset pin or power cycle wake.
// - chip select toggling or held low does not wake the device.
// - abort ends a running operation at once, write-enable not needed.
// - abort acts only when abort-enable bit, set by status 2 write, is one.
// - abort opcode plus confirmation byte, later bytes ignored.
// - page or block contents are undefined after an abort.
// - abort keeps configuration and abort-enable, clears write-enable latch.
// - abort needs both bytes and a whole-byte chip select rise.
// - wake opcode then chip select rise returns to standby within exit time.
// - in-band reset is 0101 on four chip select rises without clock.
// - reset pin low abandons work and holds idle until released.
module sac_ctrl
   import sac_pkg::*;
#(
   parameter int EXIT_CYC = sac_pkg::SLEEP_EXIT_CYC
) (
   // system clock and reset
   input  wire logic       ref_clk,
   input  wire logic       srst,
   // flash pins; linkClk is the serial clock from the host
   input  wire logic       linkClk,
   input  wire logic       csN,
   input  wire logic       siPin,
   input  wire logic       resetPinN,
   output logic            soOut,
   output logic            soOe,
   // array engine
   input  wire logic       opStart,
   input  wire logic [1:0] opKind,
   input  wire logic       opBusy,
   input  wire logic       opDone,
   input  wire logic       opFail,
   output logic            abortPulse,
   // mode and state
   input  wire logic       octalSetReq,
   output logic            octalMode,
   output logic            sleepState,
   output logic            standbyState,
   output logic            wakePulse,
   output logic            defaultsPulse,
   // status bits
   output logic            writeEnableLatch,
   output logic            abortCommandEnable,
   output logic            autoSleepEnable,
   output logic            progEraseErrFlag
);
   import sac_pkg::*;

   // ********************************************************************
   // elaboration checks
   // ********************************************************************
   if (EXIT_CYC < 1 || EXIT_CYC >= 2**CNT_W) begin : g_chk
      $error("EXIT_CYC out of range for the wait counter");
   end

   // ********************************************************************
   // state types
   // ********************************************************************
   typedef struct packed {
      logic             csMeta, csS, csD;
      logic             siMeta, siS;
      logic             ckMeta, ckS, ckD;
      logic             rsMeta, rsS;
      logic             sawClk;
      sac_state_t       state;
      logic [CNT_W-1:0] cnt;
      logic             write_enable_latch, abortEn, autoSlp, err, octal;
      logic             armed, goSleep;
      logic [3:0]       pat;
      logic [2:0]       patLen;
      logic [7:0]       statusHold;
      logic             abortP, wakeP, dfltP;
   } sac_ref_t;

   typedef struct packed {
      logic [BITS_W-1:0] bits;
      logic [7:0]        shIn;
      logic              rd;
      logic [7:0]        outSh;
   } sac_link_t;

   typedef struct packed {
      logic [BITS_W-1:0] bits;
      logic [7:0]        b0;
      logic [7:0]        b1;
   } sac_cap_t;

   sac_ref_t  r_q, r_d;
   sac_link_t lk_q, lk_d;
   sac_cap_t  cap_q, cap_d;
   logic      soBit_q;

   // ********************************************************************
   // link domain: bit shifter, restarted by every chip select rise
   // ********************************************************************
   // bit count; past the top it steps back one byte, so long frames
   // keep their byte phase in the low three bits and still end whole
   function automatic logic [BITS_W-1:0] satInc(input logic [BITS_W-1:0] v);
      satInc = (v == BITS_MAX) ? BITS_MAX - 5'h07 : v + 5'h01;
   endfunction : satInc

   logic [BITS_W-1:0] nb;
   logic [7:0]        shNext;

   always_comb begin
      nb     = satInc(lk_q.bits);
      shNext = {lk_q.shIn[6:0], siPin};
      lk_d   = lk_q;
      lk_d.bits  = nb;
      lk_d.shIn  = shNext;
      lk_d.outSh = {lk_q.outSh[6:0], 1'b0};
      // statusHold is frozen while chip select is low, so it is stable here
      if (nb == BYTE0_BITS && shNext == OP_STATUS_RD) begin
         lk_d.rd    = 1'b1;
         lk_d.outSh = r_q.statusHold;
      end else if (lk_q.rd && nb[2:0] == 3'h0) begin
         lk_d.outSh = r_q.statusHold;                     // status repeats
      end
      // capture copies survive the chip select rise for the ref domain
      cap_d      = cap_q;
      cap_d.bits = nb;
      if (nb == BYTE0_BITS) begin
         cap_d.b0 = shNext;
      end
      if (nb == BYTE1_BITS) begin
         cap_d.b1 = shNext;
      end
   end

   // chip select high clears the frame; the clock may be stopped between
   always_ff @(posedge linkClk or posedge csN) begin
      if (csN) begin
         lk_q <= '0;
      end else begin
         lk_q <= lk_d;
      end
   end

   // capture copies are only read after a frame that had clock edges
   always_ff @(posedge linkClk) begin
      cap_q <= cap_d;
   end

   // data out changes on the falling edge so the host samples on rising
   always_ff @(negedge linkClk) begin
      soBit_q <= lk_q.outSh[7];
   end

   assign soOut = soBit_q;
   assign soOe  = lk_q.rd;

   // ********************************************************************
   // ref domain: frame decode, sleep state, status bits
   // ********************************************************************
   logic csFall, csRise, clkAct, asleep;
   logic has1, has2, whole, autoKind;

   always_comb begin
      r_d = r_q;
      // two-flop synchronisers for every pin seen by this domain
      r_d.csMeta = csN;
      r_d.csS    = r_q.csMeta;
      r_d.csD    = r_q.csS;
      r_d.siMeta = siPin;
      r_d.siS    = r_q.siMeta;
      r_d.ckMeta = linkClk;
      r_d.ckS    = r_q.ckMeta;
      r_d.ckD    = r_q.ckS;
      r_d.rsMeta = resetPinN;
      r_d.rsS    = r_q.rsMeta;
      r_d.abortP = 1'b0;
      r_d.wakeP  = 1'b0;
      r_d.dfltP  = 1'b0;

      csFall   = r_q.csD & ~r_q.csS;
      csRise   = ~r_q.csD & r_q.csS;
      clkAct   = r_q.ckS ^ r_q.ckD;
      asleep   = (r_q.state == SAC_ENTERING) || (r_q.state == SAC_SLEEP) ||
                 (r_q.state == SAC_WAKING);
      has1     = cap_q.bits >= BYTE0_BITS;
      has2     = cap_q.bits >= BYTE1_BITS;
      whole    = cap_q.bits[2:0] == 3'h0;
      autoKind = (opKind == KIND_ERASE) || (opKind == KIND_PROG) ||
                 (opKind == KIND_BUF2AR);

      // clock activity during a frame marks it as a real command
      if (csFall) begin
         r_d.sawClk = 1'b0;
      end else if (clkAct && !r_q.csS) begin
         r_d.sawClk = 1'b1;
      end

      // status image only changes between frames
      if (r_q.csS) begin
         r_d.statusHold = 8'h00;
         r_d.statusHold[ST1_BUSY] = opBusy;
         r_d.statusHold[ST1_WEL]  = r_q.write_enable_latch;
         r_d.statusHold[ST1_ERR]  = r_q.err;
         if (asleep) begin
            r_d.statusHold = STATUS_ASLEEP;
         end
      end

      // operation results; the error flag tracks the latest operation
      if (opDone) begin
         r_d.err = opFail;
         if (r_q.armed) begin
            r_d.goSleep = 1'b1;
            r_d.armed   = 1'b0;
         end
      end
      if (octalSetReq && r_q.state == SAC_STANDBY && !r_q.armed) begin
         r_d.octal = 1'b1;
      end
      // an arming start in the same cycle wins over an octal request
      if (opStart && autoKind && r_q.autoSlp && r_q.state == SAC_STANDBY) begin
         r_d.armed = 1'b1;
         r_d.octal = 1'b0;
      end

      // in-band reset: si sampled on each chip select rise without clock
      if (csRise) begin
         if (r_q.sawClk) begin
            r_d.patLen = 3'h0;
         end else begin
            r_d.pat    = {r_q.pat[2:0], r_q.siS};
            r_d.patLen = (r_q.patLen == INBAND_LEN) ? INBAND_LEN
                                                    : r_q.patLen + 3'h1;
         end
      end

      case (r_q.state)
         SAC_STANDBY: begin
            // wait one cycle after done so the error flag is settled first
            if (r_q.goSleep && !opBusy) begin
               r_d.goSleep = 1'b0;
               r_d.state   = SAC_ENTERING;
               r_d.cnt     = '0;
            end else if (csRise && r_q.sawClk) begin
               if (cap_q.b0 == OP_SLEEP && has1 && !opBusy) begin
                  r_d.state = SAC_ENTERING;
                  r_d.cnt   = '0;
               end else if (cap_q.b0 == OP_WR_EN && has1 && whole) begin
                  r_d.write_enable_latch = 1'b1;
               end else if (cap_q.b0 == OP_STAT2_WR && has2 && whole &&
                            r_q.write_enable_latch && !opBusy) begin
                  r_d.abortEn = cap_q.b1[ST2_ABORTEN];
                  r_d.autoSlp = cap_q.b1[ST2_AUTOSLP];
                  r_d.write_enable_latch     = 1'b0;
               end else if (cap_q.b0 == OP_ABORT && cap_q.b1 == OP_ABORT_CONF &&
                            has2 && whole && r_q.abortEn && opBusy) begin
                  // write-enable latch is not consulted for abort
                  r_d.abortP  = 1'b1;
                  r_d.write_enable_latch     = RST_WEL;
                  r_d.armed   = 1'b0;
                  r_d.goSleep = 1'b0;
               end
            end
         end
         SAC_ENTERING: begin
            if (r_q.cnt >= CNT_W'(SLEEP_ENTRY_CYC - 1)) begin
               r_d.state   = SAC_SLEEP;
               r_d.autoSlp = 1'b0;
            end else begin
               r_d.cnt = r_q.cnt + 1'b1;
            end
         end
         SAC_SLEEP: begin
            // chip select alone never wakes; only a whole wake opcode does
            if (csRise && r_q.sawClk && cap_q.b0 == OP_WAKE &&
                has1 && whole) begin
               r_d.state = SAC_WAKING;
               r_d.cnt   = '0;
            end
         end
         SAC_WAKING: begin
            if (r_q.cnt >= CNT_W'(EXIT_CYC - 1)) begin
               r_d.state   = SAC_STANDBY;
               r_d.wakeP   = 1'b1;
               r_d.dfltP   = 1'b1;
               r_d.write_enable_latch     = RST_WEL;
               r_d.abortEn = RST_ABORTEN;
               r_d.autoSlp = RST_AUTOSLP;
               r_d.octal   = RST_OCTAL;
            end else begin
               r_d.cnt = r_q.cnt + 1'b1;
            end
         end
         SAC_PINHOLD: begin
            r_d.state = SAC_STANDBY;
         end
         default: begin
            r_d.state = SAC_STANDBY;
         end
      endcase

      // in-band reset completes: defaults, error flag kept only from entering, sleep or waking
      if (csRise && !r_q.sawClk && r_q.patLen >= 3'h3 &&
          {r_q.pat[2:0], r_q.siS} == INBAND_PAT) begin
         r_d.state   = SAC_STANDBY;
         r_d.patLen  = 3'h0;
         r_d.wakeP   = asleep;
         r_d.dfltP   = 1'b1;
         r_d.abortP  = opBusy;
         r_d.write_enable_latch     = RST_WEL;
         r_d.abortEn = RST_ABORTEN;
         r_d.autoSlp = RST_AUTOSLP;
         r_d.octal   = RST_OCTAL;
         r_d.armed   = 1'b0;
         r_d.goSleep = 1'b0;
         r_d.err     = asleep ? r_q.err : RST_ERR;
      end

      // reset pin low overrides everything and holds the block idle
      if (!r_q.rsS) begin
         r_d.state   = SAC_PINHOLD;
         r_d.abortP  = opBusy && r_q.state != SAC_PINHOLD;
         r_d.wakeP   = asleep;
         r_d.dfltP   = r_q.state != SAC_PINHOLD;
         r_d.write_enable_latch     = RST_WEL;
         r_d.abortEn = RST_ABORTEN;
         r_d.autoSlp = RST_AUTOSLP;
         r_d.octal   = RST_OCTAL;
         r_d.armed   = 1'b0;
         r_d.goSleep = 1'b0;
         r_d.patLen  = 3'h0;
         r_d.err     = (asleep || r_q.state == SAC_PINHOLD) ? r_q.err
                                                            : RST_ERR;
      end
   end

   // power-on state is standby with idle pin levels assumed
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         r_q        <= '0;
         r_q.csMeta <= 1'b1;
         r_q.csS    <= 1'b1;
         r_q.csD    <= 1'b1;
         r_q.rsMeta <= 1'b1;
         r_q.rsS    <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   // ********************************************************************
   // outputs
   // ********************************************************************
   assign abortPulse         = r_q.abortP;
   assign octalMode          = r_q.octal;
   assign sleepState         = r_q.state == SAC_SLEEP;
   assign standbyState       = r_q.state == SAC_STANDBY;
   assign wakePulse          = r_q.wakeP;
   assign defaultsPulse      = r_q.dfltP;
   assign writeEnableLatch   = r_q.write_enable_latch;
   assign abortCommandEnable = r_q.abortEn;
   assign autoSleepEnable    = r_q.autoSlp;
   assign progEraseErrFlag   = r_q.err;
endmodule : sac_ctrl

// File: sac_ctrl_assertions.sv
module sac_ctrl_assertions (
   // clock and reset
   input wire logic       ref_clk,
   input wire logic       srst,
   // pins and engine
   input wire logic       resetPinN,
   input wire logic       opStart,
   input wire logic [1:0] opKind,
   input wire logic       opBusy,
   input wire logic       opDone,
   input wire logic       opFail,
   input wire logic       abortPulse,
   // state and flags
   input wire logic       octalMode,
   input wire logic       sleepState,
   input wire logic       standbyState,
   input wire logic       wakePulse,
   input wire logic       defaultsPulse,
   input wire logic       writeEnableLatch,
   input wire logic       abortCommandEnable,
   input wire logic       autoSleepEnable,
   input wire logic       progEraseErrFlag
);
   timeunit 1ns;
   timeprecision 1ps;
   import sac_pkg::*;
   // ******************************************
   // one domain, so clock and disable once
   // ******************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   a_power_standby: assert property ($fell(srst) |-> standbyState)
      else $error("no standby after power reset");
   a_sleep_autoclr: assert property ($rose(sleepState) |-> !autoSleepEnable)
      else $error("auto sleep bit still set in sleep");
   a_auto_serial: assert property (opStart && opKind != KIND_OTHER && autoSleepEnable |=> !octalMode)
      else $error("octal kept after auto sleep op start");
   a_abort_busy: assert property (abortPulse |-> $past(opBusy))
      else $error("abort with no running operation");
   a_abort_wel: assert property (abortPulse |=> !writeEnableLatch)
      else $error("write enable kept after abort");
   a_wake_dflt: assert property (wakePulse |=> !writeEnableLatch && !abortCommandEnable && !autoSleepEnable && !octalMode)
      else $error("flags not defaulted on wake");
   a_wake_exit: assert property (wakePulse |=> !sleepState)
      else $error("still asleep after wake");
   a_dflt_wake: assert property (wakePulse |-> defaultsPulse)
      else $error("no defaults pulse on wake");
   a_pin_hold: assert property (!resetPinN [*4] |-> !standbyState && !sleepState)
      else $error("not held idle by reset pin");
   a_err_update: assert property (opDone && opFail |=> progEraseErrFlag)
      else $error("error flag not set on failure");
endmodule : sac_ctrl_assertions

// File: sac_host_model.sv
module sac_host_model (
   // link pins driven by the host
   output logic      linkClk,
   output logic      csN,
   output logic      siPin,
   // data back from the device
   input wire logic  soOut,
   input wire logic  soOe
);
   timeunit 1ns;
   timeprecision 1ps;

   // clock parks low between frames (mode 0)
   initial begin
      linkClk = 1'b0;
      csN = 1'b1;
      siPin = 1'b0;
   end

   // one frame, msb first; a read samples the second byte time
   task automatic frame(input logic [15:0] d, input int nb,
                        output logic [7:0] rd);
      rd = 8'h00;
      csN = 1'b0;
      #100;                       // status hold needs setup after select
      for (int i = 0; i < nb; i++) begin
         siPin = d[15-i];
         #80 linkClk = 1'b1;
         if (i >= 8)
            rd = {rd[6:0], soOe ? soOut : 1'bx};  // undriven never matches
         #80 linkClk = 1'b0;
      end
      #80 csN = 1'b1;
      #100;
   endtask : frame

   // four select pulses, clock still, data 0,1,0,1 at each rise
   task automatic inband();
      for (int i = 0; i < 4; i++) begin
         siPin = i[0];
         csN = 1'b0;
         #100 csN = 1'b1;
         #100;
      end
   endtask : inband
endmodule : sac_host_model

// File: test_sleep_and_abort_cmd_ctrl.sv
module test_sleep_and_abort_cmd_ctrl;
   timeunit 1ns;
   timeprecision 1ps;
   import sac_pkg::*;
   logic       ref_clk, srst, linkClk, csN, siPin, resetPinN, soOut;
   logic       soOe, opStart, opBusy, opDone, opFail, abortPulse;
   logic       octalSetReq, octalMode, sleepState, standbyState;
   logic       wakePulse, defaultsPulse, writeEnableLatch;
   logic       abortCommandEnable, autoSleepEnable, progEraseErrFlag;
   logic [1:0] opKind;
   logic [7:0] rd;
   logic [7:0] aborts = 8'h00;
   int         failures = 0;
   int         nChecks = 0;
   int         cyc = 0;

   sac_ctrl #(.EXIT_CYC(20)) dut_u (.ref_clk, .srst, .linkClk, .csN,
      .siPin, .resetPinN, .soOut, .soOe, .opStart, .opKind, .opBusy,
      .opDone, .opFail, .abortPulse, .octalSetReq, .octalMode,
      .sleepState, .standbyState, .wakePulse, .defaultsPulse,
      .writeEnableLatch, .abortCommandEnable, .autoSleepEnable,
      .progEraseErrFlag);
   sac_host_model host_u (.linkClk, .csN, .siPin, .soOut, .soOe);

   // ******************************************
   // clock, pulse counting and hang guard
   // ******************************************
   initial ref_clk = 1'b0;
   always #5 ref_clk = ~ref_clk;
   // sampled on the falling edge, where the registered pulses are settled
   always @(negedge ref_clk) begin
      cyc++;
      if (abortPulse === 1'b1)
         aborts++;               // counted here, frames end too late
      if (cyc == 30000) begin
         failures++;
         give_verdict();
      end
   end

   task automatic give_verdict();
      $display("checks %0d failures %0d", nChecks, failures);
      if (failures == 0 && nChecks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict

   task automatic check(input string what, input logic [7:0] exp,
                        input logic [7:0] got);
      nChecks++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask : tick

   // bounded wait for a level to come high
   task automatic wait_high(ref logic s, input int lim);
      for (int i = 0; i < lim && s !== 1'b1; i++)
         tick(1);
   endtask : wait_high

   task automatic set_octal();
      octalSetReq = 1'b1;
      tick(1);
      octalSetReq = 1'b0;
      tick(1);
   endtask : set_octal

   // ******************************************
   // scenarios
   // ******************************************
   task automatic t_abort();
      opBusy = 1'b1;
      host_u.frame({OP_ABORT, OP_ABORT_CONF}, 16, rd);
      check("abort disabled", 8'h00, aborts);
      opBusy = 1'b0;
      host_u.frame({OP_WR_EN, 8'h00}, 8, rd);
      host_u.frame({OP_STATUS_RD, 8'h00}, 16, rd);
      check("awake status", 8'(1 << ST1_WEL), rd);
      host_u.frame({OP_STAT2_WR, 8'h40}, 16, rd);
      check("abort enable", 8'h01, abortCommandEnable);
      host_u.frame({OP_WR_EN, 8'h00}, 8, rd);
      opStart = 1'b1;
      opKind = KIND_PROG;
      opBusy = 1'b1;
      tick(1);
      opStart = 1'b0;
      host_u.frame({OP_ABORT, OP_ABORT_CONF}, 12, rd);
      check("abort short", 8'h00, aborts);
      host_u.frame({OP_ABORT, OP_ABORT_CONF}, 16, rd);
      check("abort done", 8'h01, aborts);
      check("wel after abort", 8'h00, writeEnableLatch);
      check("enable kept", 8'h01, abortCommandEnable);
      opBusy = 1'b0;
      tick(1);
   endtask : t_abort

   task automatic t_sleep();
      set_octal();
      opBusy = 1'b1;
      host_u.frame({OP_SLEEP, 8'h00}, 8, rd);
      tick(320);
      check("busy sleep", 8'h01, standbyState);
      opBusy = 1'b0;
      host_u.frame({OP_SLEEP, 8'h00}, 5, rd);
      tick(320);
      check("short sleep", 8'h01, standbyState);
      host_u.frame({OP_SLEEP, 8'h5A}, 16, rd);
      wait_high(sleepState, 320);
      check("sleep entry", 8'h01, sleepState);
      host_u.frame({OP_STATUS_RD, 8'h00}, 16, rd);
      check("asleep status", STATUS_ASLEEP, rd);
      host_u.frame({OP_WR_EN, 8'h00}, 8, rd);
      check("wel asleep", 8'h00, writeEnableLatch);
      host_u.frame(16'h0000, 0, rd);
      check("cs toggle", 8'h01, sleepState);
      host_u.frame({OP_WAKE, 8'h00}, 8, rd);
      wait_high(standbyState, 100);
      check("wake", 8'h01, standbyState);
      check("serial mode", 8'h00, octalMode);
      check("enable lost", 8'h00, abortCommandEnable);
   endtask : t_sleep

   // auto sleep for erase, program and buffer-to-array, each woken a different way
   task automatic t_auto(input logic [1:0] k);
      host_u.frame({OP_WR_EN, 8'h00}, 8, rd);
      host_u.frame({OP_STAT2_WR, 8'h08}, 16, rd);
      check("auto enable", 8'h01, autoSleepEnable);
      set_octal();
      opStart = 1'b1;
      opKind = k;
      opBusy = 1'b1;
      tick(1);
      opStart = 1'b0;
      check("auto serial", 8'h00, octalMode);
      tick(5);
      opDone = 1'b1;
      opFail = 1'b1;
      tick(1);
      {opDone, opFail, opBusy} = 3'b000;
      check("error flag", 8'h01, progEraseErrFlag);
      wait_high(sleepState, 320);
      check("auto sleep", 8'h01, sleepState);
      check("auto cleared", 8'h00, autoSleepEnable);
      if (k == 2'h0)
         host_u.frame({OP_WAKE, 8'h00}, 8, rd);
      else if (k == 2'h1)
         host_u.inband();
      else begin
         resetPinN = 1'b0;
         tick(6);
         check("pin hold", 8'h00, standbyState);
         resetPinN = 1'b1;
      end
      wait_high(standbyState, 100);
      check("woken", 8'h01, standbyState);
      check("error kept", 8'h01, progEraseErrFlag);
   endtask : t_auto

   task automatic t_other();
      host_u.frame({OP_WR_EN, 8'h00}, 8, rd);
      host_u.frame({OP_STAT2_WR, 8'h08}, 16, rd);
      {opStart, opBusy} = 2'b11;
      opKind = KIND_OTHER;
      tick(1);
      opStart = 1'b0;
      {opDone, opFail} = 2'b11;
      tick(1);
      {opDone, opFail, opBusy} = 3'b000;
      tick(320);
      check("no auto sleep", 8'h01, standbyState);
      check("other error", 8'h01, progEraseErrFlag);
      host_u.inband();
      tick(10);
      check("inband standby", 8'h01, standbyState);
      check("inband defaults", 8'h00, autoSleepEnable);
      check("error cleared", 8'h00, progEraseErrFlag);
   endtask : t_other

   // main sequence
   initial begin
      {srst, resetPinN} = 2'b11;
      {opStart, opBusy, opDone, opFail, octalSetReq} = 5'h00;
      opKind = KIND_ERASE;
      repeat (2) @(posedge ref_clk);
      #1 srst = 1'b0;
      tick(3);
      check("power standby", 8'h01, standbyState);
      check("power flags", 8'h00, {writeEnableLatch, abortCommandEnable,
            autoSleepEnable, progEraseErrFlag, octalMode});
      t_abort();
      t_sleep();
      for (int k = 0; k < 3; k++)
         t_auto(k[1:0]);
      t_other();
      give_verdict();
   end
endmodule : test_sleep_and_abort_cmd_ctrl

bind sac_ctrl sac_ctrl_assertions chk_u (.ref_clk, .srst, .resetPinN,
   .opStart, .opKind, .opBusy, .opDone, .opFail, .abortPulse, .octalMode,
   .sleepState, .standbyState, .wakePulse, .defaultsPulse,
   .writeEnableLatch, .abortCommandEnable, .autoSleepEnable,
   .progEraseErrFlag);
